// file: ifcc_top.sv
`include "ifcc_cfg.svh"

module ifcc_top #(
  parameter logic [39:0] STARTUP_CYC = 40'(`IFCC_STARTUP_S * `IFCC_CLK_HZ),
  parameter logic [39:0] OIL_PERIOD_CYC = 40'(`IFCC_OIL_PERIOD_S * `IFCC_CLK_HZ),
  parameter logic [39:0] OIL_LEN_CYC = 40'(`IFCC_OIL_LEN_S * `IFCC_CLK_HZ)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Holding register access from the protocol engine
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_ack,
  // Unit straps, external pins
  input wire logic [1:0] fan_kind,
  input wire logic [1:0] comp_kind,
  input wire logic min_cap_close,
  // Plant condition pins
  input wire logic comp_running,
  input wire logic heat_cmd,
  input wire logic fan_run_cmd,
  input wire logic coil_warm,
  input wire logic deice_active,
  input wire logic protect_req,
  // Speed optimiser on the same clock
  input wire logic opt_valid,
  input wire logic [9:0] opt_level,
  // Indoor fan outputs
  output logic fan_on,
  output logic [9:0] fan_level,
  output ifcc_pkg::ifcc_fan3_t fan3_speed,
  // Capacity outputs
  output logic [6:0] cap_out,
  output logic startup_active,
  output logic oil_active
);
  import ifcc_pkg::*;

  localparam int NPIN = 9;

  logic [15:0] fan_mode_q;
  logic [15:0] fan_speed_q;
  logic [15:0] cap_demand_q;
  logic [NPIN-1:0] sync1_q;
  logic [NPIN-1:0] sync2_q;
  logic [NPIN-1:0] sync3_q;
  logic [NPIN-1:0] pin_q;
  logic [NPIN-1:0] pin_raw;
  ifcc_fan_kind_t fkind;
  ifcc_comp_kind_t ckind;
  logic close_sel;
  logic comp_on;
  logic heat_on;
  logic run_on;
  logic warm_ok;
  logic deice_on;
  logic protect_on;
  logic comp_on_prev_q;
  logic comp_start;
  logic [9:0] spd_val;
  logic [9:0] vs_level;
  logic [6:0] dem_val;
  logic basic_run_q;
  logic basic_run_d;
  ifcc_fan3_t f3_state;
  logic hold_off;
  logic fan_on_d;
  logic [9:0] level_d;
  logic [39:0] startup_cnt_q;
  logic [39:0] oil_wait_q;
  logic [39:0] oil_len_q;
  logic cap_en;
  logic oil_due;
  logic [6:0] cap_d;
  logic [6:0] min_cap;

  // Pins are filtered: a new level is taken once the second and third stages agree.
  assign pin_raw = {comp_kind, fan_kind, min_cap_close, comp_running, heat_cmd, fan_run_cmd, coil_warm};

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++)
    begin : g_pin
      always_ff @(posedge clk or negedge rstn)
      begin
        if (!rstn)
        begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
          sync3_q[gi] <= 1'b0;
          pin_q[gi] <= 1'b0;
        end
        else
        begin
          sync1_q[gi] <= pin_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
          sync3_q[gi] <= sync2_q[gi];
          if (sync2_q[gi] == sync3_q[gi])
            pin_q[gi] <= sync3_q[gi];
        end
      end
    end
  endgenerate

  // De-ice and protection requests come from the plant algorithms on this clock.
  assign deice_on = deice_active;
  assign protect_on = protect_req;
  assign warm_ok = pin_q[0];
  assign run_on = pin_q[1];
  assign heat_on = pin_q[2];
  assign comp_on = pin_q[3];
  assign close_sel = pin_q[4];
  assign fkind = ifcc_fan_kind_t'(pin_q[6:5]);
  assign ckind = ifcc_comp_kind_t'(pin_q[8:7]);

  // Register writes.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      fan_mode_q <= `IFCC_RST_FAN_MODE;
      fan_speed_q <= `IFCC_RST_FAN_SPEED;
      cap_demand_q <= `IFCC_RST_CAP_DEMAND;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `IFCC_ADDR_FAN_MODE)
        fan_mode_q <= reg_wdata;
      else if (reg_addr == `IFCC_ADDR_FAN_SPEED)
        fan_speed_q <= reg_wdata;
      else if (reg_addr == `IFCC_ADDR_CAP_DEMAND)
        cap_demand_q <= reg_wdata;
    end
  end

  // Register reads and acknowledge; unmapped addresses read zero.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      reg_rdata <= 16'h0000;
      reg_ack <= 1'b0;
    end
    else
    begin
      reg_ack <= reg_wr | reg_rd;
      if (!reg_rd)
        reg_rdata <= 16'h0000;
      else if (reg_addr == `IFCC_ADDR_FAN_MODE)
        reg_rdata <= fan_mode_q;
      else if (reg_addr == `IFCC_ADDR_FAN_SPEED)
        reg_rdata <= fan_speed_q;
      else if (reg_addr == `IFCC_ADDR_CAP_DEMAND)
        reg_rdata <= cap_demand_q;
      else
        reg_rdata <= 16'h0000;
    end
  end

  // Out-of-range writes are clipped rather than trusted.
  assign spd_val = (fan_speed_q > 16'(`IFCC_SPD_MAX)) ? `IFCC_SPD_MAX : fan_speed_q[9:0];
  assign dem_val = (cap_demand_q > 16'(`IFCC_CAP_MAX)) ? `IFCC_CAP_MAX : cap_demand_q[6:0];

  // Level 100 stands for minimum speed and 1000 for maximum; the drive scales between its set points.
  assign vs_level = (spd_val < `IFCC_SPD_MIN_MAP) ? `IFCC_SPD_MIN_MAP : spd_val;

  // Run decision for single and variable speed fans.
  always_comb
  begin
    basic_run_d = basic_run_q;
    if (!basic_run_q)
    begin
      if (spd_val >= `IFCC_SPD_START)
        basic_run_d = 1'b1;
    end
    else if (spd_val == 10'h000)
    begin
      if (fkind == IFCC_FAN_SINGLE)
        basic_run_d = 1'b0;
      else if (!comp_on)
        basic_run_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      basic_run_q <= 1'b0;
    else if (fkind == IFCC_FAN_THREE)
      basic_run_q <= 1'b0;
    else
      basic_run_q <= basic_run_d;
  end

  ifcc_fan3 u_fan3 (
    .clk(clk),
    .rstn(rstn),
    .enable(fkind == IFCC_FAN_THREE),
    .cmd_val(spd_val),
    .comp_on(comp_on),
    .speed(f3_state)
  );

  // Conditions that force the fan off regardless of the speed command.
  always_comb
  begin
    hold_off = 1'b0;
    if (!fan_mode_q[`IFCC_MODE_NO_WARM_BIT] && heat_on && run_on && !(comp_on && warm_ok))
      hold_off = 1'b1;
    if (deice_on && !fan_mode_q[`IFCC_MODE_DEICE_RUN_BIT])
      hold_off = 1'b1;
    if (protect_on && !fan_mode_q[`IFCC_MODE_FAN_ON_BIT])
      hold_off = 1'b1;
  end

  // Final fan command; protection in fan-on mode never stops the fan and lowers only a variable-speed fan to minimum.
  always_comb
  begin
    if (fkind == IFCC_FAN_THREE)
      fan_on_d = (f3_state != IFCC_F3_OFF);
    else
      fan_on_d = basic_run_q;
    if (fkind == IFCC_FAN_SINGLE)
      level_d = `IFCC_SPD_MAX;
    else if (fkind == IFCC_FAN_THREE)
      level_d = `IFCC_SPD_MIN_MAP;
    else if (!fan_mode_q[`IFCC_MODE_FIXED_BIT] && opt_valid)
      level_d = (opt_level < `IFCC_SPD_MIN_MAP) ? `IFCC_SPD_MIN_MAP : opt_level;
    else
      level_d = vs_level;
    if (fan_on_d && protect_on && fan_mode_q[`IFCC_MODE_FAN_ON_BIT] && fkind == IFCC_FAN_VARIABLE)
      level_d = `IFCC_SPD_MIN_MAP;
    if (hold_off)
      fan_on_d = 1'b0;
    if (!fan_on_d)
      level_d = 10'h000;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      fan_on <= 1'b0;
      fan_level <= 10'h000;
      fan3_speed <= IFCC_F3_OFF;
    end
    else
    begin
      fan_on <= fan_on_d;
      fan_level <= level_d;
      if (fkind == IFCC_FAN_THREE && fan_on_d)
        fan3_speed <= f3_state;
      else
        fan3_speed <= IFCC_F3_OFF;
    end
  end

  // Compressor start detection and start-up window.
  assign comp_start = comp_on && !comp_on_prev_q;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      comp_on_prev_q <= 1'b0;
    else
      comp_on_prev_q <= comp_on;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      startup_cnt_q <= 40'h00_0000_0000;
    else if (!comp_on)
      startup_cnt_q <= 40'h00_0000_0000;
    else if (comp_start)
      startup_cnt_q <= STARTUP_CYC;
    else if (startup_cnt_q != 40'h00_0000_0000)
      startup_cnt_q <= startup_cnt_q - 40'h00_0000_0001;
  end

  // Oil recovery: the wait counter runs with the compressor and is rearmed by each cycle.
  assign oil_due = (oil_wait_q >= OIL_PERIOD_CYC) && comp_on && cap_en && (startup_cnt_q == 40'h00_0000_0000);

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      oil_wait_q <= 40'h00_0000_0000;
      oil_len_q <= 40'h00_0000_0000;
    end
    else if (oil_len_q != 40'h00_0000_0000)
    begin
      if (comp_on)
        oil_len_q <= oil_len_q - 40'h00_0000_0001;
      else
        oil_len_q <= 40'h00_0000_0000;
    end
    else if (oil_due)
    begin
      oil_len_q <= OIL_LEN_CYC;
      oil_wait_q <= 40'h00_0000_0000;
    end
    else if (comp_on && oil_wait_q < OIL_PERIOD_CYC)
      oil_wait_q <= oil_wait_q + 40'h00_0000_0001;
  end

  // Capacity decision.
  assign cap_en = (ckind == IFCC_COMP_SCROLL) || (ckind == IFCC_COMP_VSPEED);
  assign min_cap = close_sel ? `IFCC_CAP_MIN_CLOSE : `IFCC_CAP_MIN_NORMAL;

  always_comb
  begin
    cap_d = (dem_val < min_cap) ? min_cap : dem_val;
    if (startup_cnt_q != 40'h00_0000_0000)
    begin
      if (ckind == IFCC_COMP_VSPEED)
        cap_d = `IFCC_CAP_VS_START;
      else if (cap_d < `IFCC_CAP_SCROLL_START)
        cap_d = `IFCC_CAP_SCROLL_START;
    end
    else if (oil_len_q != 40'h00_0000_0000)
      cap_d = `IFCC_CAP_OIL;
    if (!comp_on || !cap_en)
      cap_d = 7'h00;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cap_out <= 7'h00;
      startup_active <= 1'b0;
      oil_active <= 1'b0;
    end
    else
    begin
      cap_out <= cap_d;
      startup_active <= (startup_cnt_q != 40'h00_0000_0000);
      oil_active <= (oil_len_q != 40'h00_0000_0000);
    end
  end

endmodule

// file: ifcc_cfg.svh
// Function
// - Mode bit 0 clear lets the controller pick an optimised indoor fan speed; applied to variable-speed fans only.
// - Mode bit 0 set keeps the indoor fan at the written speed value.
// - Mode bit 1 clear lets protection stop the indoor fan completely.
// - Mode bit 1 set lets protection slow a variable-speed fan, never below minimum.
// - Mode bit 2 clear stops the fan during de-ice; set keeps it running.
// - Warm start holds fan off until compressor runs and coil reaches 26 C.
// - Stopped single-speed fan starts on 50 to 1000, stays off below 50.
// - Running single-speed fan stops only on value 0.
// - Variable-speed fan stops on 0 only while the compressor is off.
// - Variable-speed fan starts at 50; 50-100 minimum, 100-1000 linear to maximum.
// - Three-speed fan stops on 0 only while compressor is off, else low.
// - Stopped three-speed fan starts on 50 or more, stays off below 50.
// - At low: 0 stops, 450 or more steps up, 1-449 holds low.
// - At medium: 349 or less steps down, 800 or more steps to high.
// - At high: 699 or less steps down, 700-1000 holds high.
// - Capacity ignored for fixed-capacity units, applied to running variable ones.
// - Running compressor demand is raised to 40 percent, or 16 with switch.
// - Digital scroll has a 75 percent floor for two minutes after start.
// - Variable-speed compressor runs fixed 50 percent for two minutes after start.
// - Oil recovery overrides capacity at most every 100 minutes for one minute.
`ifndef IFCC_CFG_SVH
`define IFCC_CFG_SVH

`define IFCC_ADDR_FAN_MODE 16'h0069
`define IFCC_ADDR_FAN_SPEED 16'h006C
`define IFCC_ADDR_CAP_DEMAND 16'h006D

`define IFCC_RST_FAN_MODE 16'h0000
`define IFCC_RST_FAN_SPEED 16'h0000
`define IFCC_RST_CAP_DEMAND 16'h0000

`define IFCC_MODE_FIXED_BIT 0
`define IFCC_MODE_FAN_ON_BIT 1
`define IFCC_MODE_DEICE_RUN_BIT 2
`define IFCC_MODE_NO_WARM_BIT 3

`define IFCC_SPD_MAX 10'h3E8
`define IFCC_SPD_START 10'h032
`define IFCC_SPD_MIN_MAP 10'h064
`define IFCC_SPD3_UP_LOW 10'h1C2
`define IFCC_SPD3_DN_MED 10'h15D
`define IFCC_SPD3_UP_MED 10'h320
`define IFCC_SPD3_DN_HIGH 10'h2BB

`define IFCC_CAP_MAX 7'h64
`define IFCC_CAP_MIN_NORMAL 7'h28
`define IFCC_CAP_MIN_CLOSE 7'h10
`define IFCC_CAP_SCROLL_START 7'h4B
`define IFCC_CAP_VS_START 7'h32
`define IFCC_CAP_OIL 7'h64

`define IFCC_CLK_HZ 64'h1312D00
`define IFCC_STARTUP_S 64'h78
`define IFCC_OIL_PERIOD_S 64'h1770
`define IFCC_OIL_LEN_S 64'h3C

`endif

// file: ifcc_pkg.sv
package ifcc_pkg;

  typedef enum logic [1:0] {
    IFCC_FAN_SINGLE,
    IFCC_FAN_VARIABLE,
    IFCC_FAN_THREE,
    IFCC_FAN_SPARE
  } ifcc_fan_kind_t;

  typedef enum logic [1:0] {
    IFCC_COMP_FIXED,
    IFCC_COMP_SCROLL,
    IFCC_COMP_VSPEED,
    IFCC_COMP_SPARE
  } ifcc_comp_kind_t;

  typedef enum logic [1:0] {
    IFCC_F3_OFF,
    IFCC_F3_LOW,
    IFCC_F3_MED,
    IFCC_F3_HIGH
  } ifcc_fan3_t;

endpackage

// file: ifcc_fan3.sv
`include "ifcc_cfg.svh"

module ifcc_fan3 (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Decision inputs
  input wire logic enable,
  input wire logic [9:0] cmd_val,
  input wire logic comp_on,
  // Speed state
  output ifcc_pkg::ifcc_fan3_t speed
);
  import ifcc_pkg::*;

  ifcc_fan3_t state_q;
  ifcc_fan3_t state_d;

  assign speed = state_q;

  // One step per evaluation, so a large value from off climbs through low first.
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      IFCC_F3_OFF:
      begin
        if (cmd_val >= `IFCC_SPD_START)
          state_d = IFCC_F3_LOW;
      end
      IFCC_F3_LOW:
      begin
        if (cmd_val == 10'h000 && !comp_on)
          state_d = IFCC_F3_OFF;
        else if (cmd_val >= `IFCC_SPD3_UP_LOW)
          state_d = IFCC_F3_MED;
      end
      IFCC_F3_MED:
      begin
        if (cmd_val <= `IFCC_SPD3_DN_MED)
          state_d = IFCC_F3_LOW;
        else if (cmd_val >= `IFCC_SPD3_UP_MED)
          state_d = IFCC_F3_HIGH;
      end
      default:
      begin
        if (cmd_val <= `IFCC_SPD3_DN_HIGH)
          state_d = IFCC_F3_MED;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      state_q <= IFCC_F3_OFF;
    else if (!enable)
      state_q <= IFCC_F3_OFF;
    else
      state_q <= state_d;
  end

endmodule

// file: ifcc_props.sv
module ifcc_props #(
  parameter logic [39:0] STARTUP_CYC = 40'h14,
  parameter logic [39:0] OIL_PERIOD_CYC = 40'hC8,
  parameter logic [39:0] OIL_LEN_CYC = 40'hA
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register port
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_ack,
  // Straps and plant
  input wire logic [1:0] fan_kind,
  input wire logic [1:0] comp_kind,
  input wire logic min_cap_close,
  input wire logic comp_running,
  input wire logic heat_cmd,
  input wire logic fan_run_cmd,
  input wire logic coil_warm,
  input wire logic deice_active,
  input wire logic protect_req,
  input wire logic opt_valid,
  input wire logic [9:0] opt_level,
  // Outputs
  input wire logic fan_on,
  input wire logic [9:0] fan_level,
  input ifcc_pkg::ifcc_fan3_t fan3_speed,
  input wire logic [6:0] cap_out,
  input wire logic startup_active,
  input wire logic oil_active
);
  import ifcc_pkg::*;
  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  sequence s_vs_kind;
    (comp_kind == 2'h2) [*8];
  endsequence
  sequence s_oil_run;
    oil_active [*8] ##[1:4] !oil_active;
  endsequence
  ack_after_strobe_a: assert property ((reg_wr || reg_rd) |=> reg_ack)
    else $error("no ack after access");
  cap_ceiling_a: assert property (cap_out <= 7'h64)
    else $error("capacity above full");
  cap_floor_a: assert property ((!min_cap_close) [*8] ##1 cap_out != 7'h0 |-> cap_out >= 7'h28)
    else $error("capacity under minimum");
  fixed_ignored_a: assert property ((comp_kind == 2'h0) [*8] |=> cap_out == 7'h0)
    else $error("fixed unit shows capacity");
  vs_startup_a: assert property (s_vs_kind ##1 (startup_active && cap_out != 7'h0) |-> cap_out == 7'h32)
    else $error("start-up capacity not fixed");
  oil_length_a: assert property ($rose(oil_active) |-> s_oil_run)
    else $error("oil cycle length wrong");
  oil_full_a: assert property ($past(oil_active) && oil_active && cap_out != 7'h0 |-> cap_out == 7'h64)
    else $error("oil cycle not at full");
  three_step_a: assert property ($changed(fan3_speed) |-> ({1'b0, fan3_speed} == {1'b0, $past(fan3_speed)} + 3'h1)
    || ({1'b0, $past(fan3_speed)} == {1'b0, fan3_speed} + 3'h1))
    else $error("fan speed jumped");
  fan_floor_a: assert property (fan_on |-> fan_level >= 10'h064)
    else $error("running fan under minimum");
endmodule

bind ifcc_top ifcc_props #(.STARTUP_CYC(STARTUP_CYC), .OIL_PERIOD_CYC(OIL_PERIOD_CYC), .OIL_LEN_CYC(OIL_LEN_CYC))
  i_props (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .reg_ack(reg_ack), .fan_kind(fan_kind), .comp_kind(comp_kind),
  .min_cap_close(min_cap_close), .comp_running(comp_running), .heat_cmd(heat_cmd), .fan_run_cmd(fan_run_cmd),
  .coil_warm(coil_warm), .deice_active(deice_active), .protect_req(protect_req), .opt_valid(opt_valid),
  .opt_level(opt_level), .fan_on(fan_on), .fan_level(fan_level), .fan3_speed(fan3_speed), .cap_out(cap_out),
  .startup_active(startup_active), .oil_active(oil_active));

// file: ifcc_bms_model.sv
module ifcc_bms_model (
  // Clock
  input wire logic clk,
  // Register port
  output logic [15:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    reg_addr = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 16'h0000;
  end
  // One access; the answer stands for one cycle, so it is taken right after that edge.
  task automatic xfer(input logic wr, input logic [15:0] a, input logic [15:0] d,
                      output logic [15:0] q, output logic ok);
    @(posedge clk);
    #2;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = wr;
    reg_rd = !wr;
    @(posedge clk);
    #2;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ok = reg_ack;
    q = reg_rdata;
    // Released lines show a changed value so stale data is never mistaken for valid.
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
endmodule

// file: indoor_fan_capacity_command_tb.sv
`include "ifcc_cfg.svh"

module indoor_fan_capacity_command_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ifcc_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, rd_q;
  logic reg_wr, reg_rd, reg_ack, ack_q, fan_on, startup_active, oil_active;
  logic [1:0] fan_kind = 2'h0;
  logic [1:0] comp_kind = 2'h0;
  logic min_cap_close = 1'b0, comp_running = 1'b0, heat_cmd = 1'b0, fan_run_cmd = 1'b0, coil_warm = 1'b0;
  logic deice_active = 1'b0, protect_req = 1'b0, opt_valid = 1'b0;
  logic [9:0] opt_level = 10'h000;
  logic [9:0] fan_level;
  logic [6:0] cap_out;
  ifcc_fan3_t fan3_speed;
  int err_count = 0;
  int checks = 0;
  logic [15:0] v3 [13] = '{16'h0031, 16'h0064, 16'h01C1, 16'h01C2, 16'h031F, 16'h0320, 16'h02BC, 16'h02BB,
                           16'h015E, 16'h015D, 16'h0001, 16'h0000, 16'h03E8};
  ifcc_fan3_t e3 [13] = '{IFCC_F3_OFF, IFCC_F3_LOW, IFCC_F3_LOW, IFCC_F3_MED, IFCC_F3_MED, IFCC_F3_HIGH,
                          IFCC_F3_HIGH, IFCC_F3_MED, IFCC_F3_MED, IFCC_F3_LOW, IFCC_F3_LOW, IFCC_F3_OFF, IFCC_F3_HIGH};

  ifcc_bms_model i_bms (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack));
  ifcc_top #(.STARTUP_CYC(40'h14), .OIL_PERIOD_CYC(40'hC8), .OIL_LEN_CYC(40'hA)) i_dut (.clk(clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_ack(reg_ack), .fan_kind(fan_kind), .comp_kind(comp_kind), .min_cap_close(min_cap_close),
    .comp_running(comp_running), .heat_cmd(heat_cmd), .fan_run_cmd(fan_run_cmd), .coil_warm(coil_warm),
    .deice_active(deice_active), .protect_req(protect_req), .opt_valid(opt_valid), .opt_level(opt_level),
    .fan_on(fan_on), .fan_level(fan_level), .fan3_speed(fan3_speed), .cap_out(cap_out),
    .startup_active(startup_active), .oil_active(oil_active));

  initial
  begin
    forever #25 clk = ~clk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (err_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Pins pass a filter and outputs follow a few edges later, so eight edges cover both.
  task automatic settle();
    repeat (8) @(posedge clk);
    #2;
  endtask

  task automatic put(input logic [15:0] a, input logic [15:0] d);
    i_bms.xfer(1'b1, a, d, rd_q, ack_q);
    settle();
  endtask

  task automatic get(input logic [15:0] a);
    i_bms.xfer(1'b0, a, 16'h0000, rd_q, ack_q);
  endtask

  task automatic fan_chk(input logic [15:0] spd, input logic on, input logic [9:0] lvl);
    put(`IFCC_ADDR_FAN_SPEED, spd);
    chk(fan_on, on);
    chk(fan_level, lvl);
  endtask

  initial
  begin
    repeat (3) @(posedge clk);
    #2;
    rstn = 1'b1;
    get(`IFCC_ADDR_FAN_MODE);
    chk(rd_q, 16'h0000);
    put(`IFCC_ADDR_CAP_DEMAND, 16'h000A);
    chk(ack_q, 1'b1);
    get(`IFCC_ADDR_CAP_DEMAND);
    chk(rd_q, 16'h000A);
    get(16'h006A);
    chk(rd_q, 16'h0000);
    put(`IFCC_ADDR_FAN_MODE, 16'h0001);
    fan_chk(16'h0031, 1'b0, 10'h000);
    fan_chk(16'h0032, 1'b1, 10'h3E8);
    fan_chk(16'h0001, 1'b1, 10'h3E8);
    fan_chk(16'h0000, 1'b0, 10'h000);
    fan_kind = 2'h1;
    fan_chk(16'h0031, 1'b0, 10'h000);
    fan_chk(16'h004B, 1'b1, 10'h064);
    fan_chk(16'h03E8, 1'b1, 10'h3E8);
    comp_running = 1'b1;
    fan_chk(16'h0226, 1'b1, 10'h226);
    chk(cap_out, 7'h00);
    fan_chk(16'h0000, 1'b1, 10'h064);
    fan_chk(16'h0226, 1'b1, 10'h226);
    protect_req = 1'b1;
    put(`IFCC_ADDR_FAN_MODE, 16'h0003);
    chk(fan_level, 10'h064);
    put(`IFCC_ADDR_FAN_MODE, 16'h0001);
    chk(fan_on, 1'b0);
    protect_req = 1'b0;
    deice_active = 1'b1;
    settle();
    chk(fan_on, 1'b0);
    put(`IFCC_ADDR_FAN_MODE, 16'h0005);
    chk(fan_level, 10'h226);
    deice_active = 1'b0;
    heat_cmd = 1'b1;
    fan_run_cmd = 1'b1;
    put(`IFCC_ADDR_FAN_MODE, 16'h0001);
    chk(fan_on, 1'b0);
    coil_warm = 1'b1;
    settle();
    chk(fan_on, 1'b1);
    heat_cmd = 1'b0;
    opt_valid = 1'b1;
    opt_level = 10'h12C;
    settle();
    chk(fan_level, 10'h226);
    put(`IFCC_ADDR_FAN_MODE, 16'h0000);
    chk(fan_level, 10'h12C);
    opt_valid = 1'b0;
    comp_running = 1'b0;
    fan_chk(16'h0000, 1'b0, 10'h000);
    fan_kind = 2'h2;
    settle();
    for (int i = 0; i < 13; i++)
    begin
      put(`IFCC_ADDR_FAN_SPEED, v3[i]);
      chk(fan3_speed, e3[i]);
    end
    comp_running = 1'b1;
    put(`IFCC_ADDR_FAN_SPEED, 16'h0000);
    chk(fan3_speed, IFCC_F3_LOW);
    comp_running = 1'b0;
    settle();
    chk(fan3_speed, IFCC_F3_OFF);
    comp_kind = 2'h2;
    settle();
    comp_running = 1'b1;
    settle();
    chk(startup_active, 1'b1);
    chk(cap_out, 7'h32);
    repeat (20) @(posedge clk);
    #2;
    chk(startup_active, 1'b0);
    chk(cap_out, 7'h28);
    min_cap_close = 1'b1;
    settle();
    chk(cap_out, 7'h10);
    put(`IFCC_ADDR_CAP_DEMAND, 16'h005A);
    chk(cap_out, 7'h5A);
    for (int n = 0; n < 300 && oil_active !== 1'b1; n++)
    begin
      @(posedge clk);
      #2;
    end
    chk(oil_active, 1'b1);
    repeat (2) @(posedge clk);
    #2;
    chk(cap_out, 7'h64);
    repeat (12) @(posedge clk);
    #2;
    chk(cap_out, 7'h5A);
    comp_running = 1'b0;
    settle();
    chk(cap_out, 7'h00);
    comp_kind = 2'h1;
    min_cap_close = 1'b0;
    put(`IFCC_ADDR_CAP_DEMAND, 16'h000A);
    comp_running = 1'b1;
    settle();
    chk(cap_out, 7'h4B);
    repeat (20) @(posedge clk);
    #2;
    chk(cap_out, 7'h28);
    comp_kind = 2'h0;
    settle();
    chk(cap_out, 7'h00);
    results();
  end
endmodule
